//--- logic/ufr_hcs.sv
// Header check sum over the fragment descriptor fields
`timescale 1ns/1ps
module ufr_hcs (
   input wire logic fragd, // Fragment header present
   input wire logic first, // First flag
   input wire logic last, // Last flag
   input wire ufr_pkg::ufr_seq_t seq, // Sequence number
   input wire ufr_pkg::ufr_len_t pb, // Piggyback request
   input wire ufr_pkg::ufr_len_t len, // Payload length
   output logic [7:0] hcs // Check byte
);
   import ufr_pkg::*;
   // Byte fold, cheap and same on both ends
   assign hcs = {fragd, first, last, 1'b0, seq} ^ pb[15:8] ^ pb[7:0]
      ^ len[15:8] ^ len[7:0] ^ 8'hA5;
endmodule : ufr_hcs

//--- logic/ufr_headend.sv
// Headend end: grants bandwidth, reassembles fragments, APB control
`timescale 1ns/1ps
`include "ufr_map.svh"
module ufr_headend #(
   parameter int MAP_CYC = `UFR_MAP_CYC
) (
   input wire logic clk_sys, // System clock
   input wire logic nrst, // Async reset, active low
   ufr_if.headend lnk, // Link to modem
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, never set
   output logic frame_ok, // Frame received, pulse
   output ufr_pkg::ufr_len_t frame_len, // Its byte count
   output ufr_pkg::ufr_len_t dec_off // Decrypt start offset
);
   import ufr_pkg::*;
   logic [2:0] ctrl_q;
   ufr_len_t maxg_q, outst_q, frames_q, g, left, asm_q;
   int map_q;
   logic tick, hcs_ok, asm_on_q, ok_q, mv_q, mp_q;
   ufr_len_t mg_q, flen_q, doff_q;
   ufr_seq_t exp_q;
   logic [7:0] hcs_c;
   logic [31:0] rd_q;

   ufr_hcs u_hcs (
      .fragd(lnk.frag_fragd),
      .first(lnk.frag_first),
      .last(lnk.frag_last),
      .seq(lnk.frag_seq),
      .pb(lnk.frag_pb),
      .len(lnk.frag_len),
      .hcs(hcs_c)
   );

   always_comb begin
      tick = (map_q >= MAP_CYC - 1);
      hcs_ok = lnk.frag_valid && (hcs_c == lnk.frag_hcs);
      g = (outst_q > maxg_q) ? maxg_q : outst_q;
      left = outst_q - g;
      // never leave a remainder below one fragment
      if (left != 16'h0000 && left <= `UFR_FRAG_OVH + `UFR_POH) begin
         g = outst_q - `UFR_FRAG_OVH - `UFR_POH - 16'h0001;
         left = `UFR_FRAG_OVH + `UFR_POH + 16'h0001;
      end
   end

   // APB slave, zero wait states
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= 3'h0;
         maxg_q <= `UFR_MAX_GRANT_RST;
         rd_q <= 32'h0000_0000;
      end else if (psel && !penable) begin
         unique case (paddr)
            `UFR_REG_CTRL: rd_q <= {29'h0, ctrl_q};
            `UFR_REG_MAXG: rd_q <= {16'h0, maxg_q};
            `UFR_REG_FRAMES: rd_q <= {16'h0, frames_q};
            `UFR_REG_OUTST: rd_q <= {16'h0, outst_q};
            default: rd_q <= 32'h0000_0000;
         endcase
      end else if (psel && penable && pwrite) begin
         if (paddr == `UFR_REG_CTRL) begin
            ctrl_q <= pwdata[2:0];
         end
         if (paddr == `UFR_REG_MAXG) begin
            maxg_q <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         map_q <= 0;
      end else begin
         map_q <= tick ? 0 : map_q + 1;
      end
   end

   // Grant engine
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         outst_q <= 16'h0000;
         mv_q <= 1'b0;
         mg_q <= 16'h0000;
         mp_q <= 1'b0;
      end else begin
         mv_q <= tick;
         if (tick) begin
            if (ctrl_q[`UFR_CTRL_HOLD]) begin
               // zero-length pending while unable to grant
               mg_q <= 16'h0000;
               mp_q <= ctrl_q[`UFR_CTRL_MGMODE] && (outst_q != 16'h0000);
            end else begin
               mg_q <= g;
               mp_q <= ctrl_q[`UFR_CTRL_MGMODE] && (left != 16'h0000);
            end
         end
         if (lnk.req_valid) begin
            outst_q <= lnk.req_len;
         end else if (hcs_ok && lnk.frag_pb != 16'h0000) begin
            outst_q <= lnk.frag_pb;
         end else if (tick && !ctrl_q[`UFR_CTRL_HOLD]) begin
            // Piggyback mode keeps no remainder state
            outst_q <= ctrl_q[`UFR_CTRL_MGMODE] ? left : 16'h0000;
         end
      end
   end

   // Reassembly; a re-request leaves it untouched
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         asm_on_q <= 1'b0;
         asm_q <= 16'h0000;
         exp_q <= 4'h0;
         ok_q <= 1'b0;
         flen_q <= 16'h0000;
         doff_q <= 16'h0000;
         frames_q <= 16'h0000;
      end else begin
         ok_q <= 1'b0;
         if (hcs_ok) begin
            exp_q <= lnk.frag_seq + 4'h1;
            // fragments decrypt from end of fragment header
            doff_q <= lnk.frag_fragd ? `UFR_FRAGMENT_HEADER_LEN : `UFR_PKT_ENC_OFF;
            if (!lnk.frag_fragd) begin
               ok_q <= 1'b1;
               flen_q <= lnk.frag_len;
               frames_q <= frames_q + 16'h0001;
            end else if (lnk.frag_first) begin
               asm_on_q <= 1'b1;
               asm_q <= lnk.frag_len;
            end else if (asm_on_q && lnk.frag_seq == exp_q) begin
               asm_q <= asm_q + lnk.frag_len;
               if (lnk.frag_last) begin
                  asm_on_q <= 1'b0;
                  ok_q <= 1'b1;
                  flen_q <= asm_q + lnk.frag_len;
                  frames_q <= frames_q + 16'h0001;
               end
            end else begin
               asm_on_q <= 1'b0;
            end
         end
      end
   end

   assign lnk.frag_cap_en = ctrl_q[`UFR_CTRL_FRAG_EN];
   assign lnk.map_valid = mv_q;
   assign lnk.map_grant = mg_q;
   assign lnk.map_pend = mp_q;
   assign prdata = rd_q;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign frame_ok = ok_q;
   assign frame_len = flen_q;
   assign dec_off = doff_q;
endmodule : ufr_headend

//--- logic/ufr_if.sv
// Link between modem and headend controller
`timescale 1ns/1ps
interface ufr_if;
   import ufr_pkg::*;
   logic frag_cap_en;
   logic map_valid;
   ufr_len_t map_grant;
   logic map_pend;
   logic req_valid;
   ufr_len_t req_len;
   logic frag_valid;
   logic frag_fragd;
   logic frag_first;
   logic frag_last;
   ufr_seq_t frag_seq;
   ufr_len_t frag_pb;
   ufr_len_t frag_len;
   logic frag_enc;
   ufr_len_t frag_enc_off;
   logic [7:0] frag_hcs;
   modport modem (
      input frag_cap_en, map_valid, map_grant, map_pend,
      output req_valid, req_len, frag_valid, frag_fragd, frag_first,
      output frag_last, frag_seq, frag_pb, frag_len, frag_enc,
      output frag_enc_off, frag_hcs
   );
   modport headend (
      output frag_cap_en, map_valid, map_grant, map_pend,
      input req_valid, req_len, frag_valid, frag_fragd, frag_first,
      input frag_last, frag_seq, frag_pb, frag_len, frag_enc,
      input frag_enc_off, frag_hcs
   );
endinterface : ufr_if

//--- logic/ufr_map.svh
// Constants of the upstream frame fragmenter, both ends
`ifndef UFR_MAP_SVH
`define UFR_MAP_SVH
// What this block does
// - Headend switches fragmentation per modem
// - Fragment only enabled flows on short grants
// - Fixed header plus CRC around portions
// - Encrypt from after header check on
// - Fill partial grant with maximum payload
// - Piggyback when no later grant known
// - Requests in fragment header, never twice
// - Request remainder plus overhead bytes
// - Re-request after ACK time, with backoff
// - Discard untransmitted part past retry limit
// - First, middle, last flag coding
// - Sequence number steps per fragment
// - Never fragment immediate data frames
// - Headend decrypts right after fragment header
// - Headend sends grant pending until granting
// - No grant or pending means re-request
// - Grant pending forbids piggyback in fragment
// - Headend keeps frame across re-requests
// - Headend keeps remainder above minimum fragment
// - Modem tracks remainder, piggybacks its length
// - Good header check passes piggyback on
// - Reassembled frame skips packet decryption
// - Queued grants mean piggyback zero
`define UFR_FRAG_OVH 16'h0010
`define UFR_FRAGMENT_CRC_LEN 16'h0004
`define UFR_FRAGMENT_HEADER_LEN (`UFR_FRAG_OVH - `UFR_FRAGMENT_CRC_LEN)
`define UFR_PKT_ENC_OFF 16'h000C
`define UFR_POH 16'h0020
`define UFR_MAX_GRANT_RST 16'h0100
`define UFR_CLK_MHZ 250
`define UFR_ACK_TIME_US 200
`define UFR_ACK_CYC (`UFR_ACK_TIME_US * `UFR_CLK_MHZ)
`define UFR_BACKOFF_TIME_US 4
`define UFR_BACKOFF_CYC (`UFR_BACKOFF_TIME_US * `UFR_CLK_MHZ)
`define UFR_MAP_TIME_US 2
`define UFR_MAP_CYC (`UFR_MAP_TIME_US * `UFR_CLK_MHZ)
`define UFR_MAX_RETRY 3
`define UFR_REG_CTRL 12'h000
`define UFR_REG_MAXG 12'h004
`define UFR_REG_FRAMES 12'h008
`define UFR_REG_OUTST 12'h00C
`define UFR_CTRL_FRAG_EN 0
`define UFR_CTRL_MGMODE 1
`define UFR_CTRL_HOLD 2
`endif

//--- logic/ufr_modem.sv
// Modem end: splits frames into fragments on partial grants
`timescale 1ns/1ps
`include "ufr_map.svh"
module ufr_modem #(
   parameter int ACK_CYC = `UFR_ACK_CYC,
   parameter int BACKOFF_CYC = `UFR_BACKOFF_CYC,
   parameter int MAX_RETRY = `UFR_MAX_RETRY
) (
   input wire logic clk_sys, // System clock
   input wire logic nrst, // Async reset, active low
   ufr_if.modem lnk, // Link to headend
   input wire logic frame_valid, // Frame offered
   input wire ufr_pkg::ufr_len_t frame_len, // Frame bytes
   input wire logic frame_frag_en, // Flow policy allows split
   input wire logic frame_imm, // Sent in request/data region
   input wire logic frame_enc, // Frame to be encrypted
   input wire logic next_valid, // Another frame queued
   input wire ufr_pkg::ufr_len_t next_len, // Its length
   output logic frame_ready, // Frame taken when valid
   output logic frame_done, // Frame fully sent, pulse
   output logic frame_drop, // Remainder discarded, pulse
   output logic next_req_sent // Next frame requested, pulse
);
   import ufr_pkg::*;
   ufr_state_e state_q, state_d;
   ufr_len_t rem_q;
   logic fen_q, imm_q, enc_q, fact_q, pbdone_q;
   ufr_seq_t seq_q, fseq_q;
   int ack_q, boff_q, retry_q;
   logic req_valid_q, frag_valid_q, fragd_q, first_q, last_q, fenc_q;
   ufr_len_t req_len_q, pb_q, flen_q, eoff_q;
   logic [7:0] hcs_q, hcs_d;
   logic ready_q, done_q, drop_q, nreq_q;
   ufr_len_t ovh, need, room, pay, pb_d;
   logic can_frag, use_full, use_part, hold, ack_exp, first_d, last_d;

   always_comb begin
      ovh = fact_q ? `UFR_FRAG_OVH : 16'h0000;
      need = rem_q + ovh + `UFR_POH;
      // split only when allowed and not immediate
      can_frag = lnk.frag_cap_en && fen_q && !imm_q;
      // payload is grant less both overheads
      room = lnk.map_grant - `UFR_POH - `UFR_FRAG_OVH;
      use_full = lnk.map_valid && (lnk.map_grant >= need);
      use_part = lnk.map_valid && !use_full && can_frag
         && (lnk.map_grant > (`UFR_POH + `UFR_FRAG_OVH));
      hold = lnk.map_pend;
      pay = use_full ? rem_q : room;
      first_d = use_part && !fact_q;
      last_d = use_full && fact_q;
      pb_d = 16'h0000;
      if (use_part && !hold) begin
         // remainder plus fragment and phy overhead
         pb_d = rem_q - room + `UFR_FRAG_OVH + `UFR_POH;
      end else if (use_full && !hold && next_valid) begin
         // next frame asked in last header only
         pb_d = next_len + `UFR_POH;
      end
      ack_exp = (ack_q >= ACK_CYC - 1);
   end

   ufr_hcs u_hcs (
      .fragd(fact_q || use_part),
      .first(first_d),
      .last(last_d),
      .seq(seq_q),
      .pb(pb_d),
      .len(pay),
      .hcs(hcs_d)
   );

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         UFR_IDLE: begin
            if (frame_valid && ready_q) begin
               state_d = pbdone_q ? UFR_WAIT : UFR_REQ;
            end
         end
         UFR_REQ: state_d = UFR_WAIT;
         UFR_WAIT: begin
            if (use_full) begin
               state_d = UFR_IDLE;
            end else if (ack_exp && !use_part && !hold) begin
               state_d = (retry_q >= MAX_RETRY) ? UFR_IDLE : UFR_BOFF;
            end
         end
         UFR_BOFF: begin
            if (boff_q >= BACKOFF_CYC - 1) begin
               state_d = UFR_REQ;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= UFR_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Frame bookkeeping
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rem_q <= 16'h0000;
         fen_q <= 1'b0;
         imm_q <= 1'b0;
         enc_q <= 1'b0;
         fact_q <= 1'b0;
      end else if (state_q == UFR_IDLE && frame_valid && ready_q) begin
         rem_q <= frame_len;
         fen_q <= frame_frag_en;
         imm_q <= frame_imm;
         enc_q <= frame_enc;
         fact_q <= 1'b0;
      end else if (state_q == UFR_WAIT && use_part) begin
         rem_q <= rem_q - room;
         fact_q <= 1'b1;
      end else if (state_q == UFR_WAIT && use_full) begin
         rem_q <= 16'h0000;
         fact_q <= 1'b0;
      end
   end

   // ACK timer, restarted by partial grants and pendings
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 0;
      end else if (state_q != UFR_WAIT || use_part || hold) begin
         ack_q <= 0;
      end else if (!ack_exp) begin
         ack_q <= ack_q + 1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         boff_q <= 0;
         retry_q <= 0;
      end else begin
         boff_q <= (state_q == UFR_BOFF) ? boff_q + 1 : 0;
         if (state_q == UFR_IDLE || use_part || hold) begin
            retry_q <= 0;
         end else if (state_q == UFR_WAIT && state_d == UFR_BOFF) begin
            retry_q <= retry_q + 1;
         end
      end
   end

   // sequence steps per fragment, wraps freely
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         seq_q <= 4'h0;
      end else if (state_q == UFR_WAIT && (use_part || last_d)) begin
         seq_q <= seq_q + 4'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         frag_valid_q <= 1'b0;
         fragd_q <= 1'b0;
         first_q <= 1'b0;
         last_q <= 1'b0;
         pb_q <= 16'h0000;
         flen_q <= 16'h0000;
         fenc_q <= 1'b0;
         eoff_q <= 16'h0000;
         hcs_q <= 8'h00;
         fseq_q <= 4'h0;
      end else begin
         frag_valid_q <= 1'b0;
         if (state_q == UFR_WAIT && (use_full || use_part)) begin
            frag_valid_q <= 1'b1;
            fragd_q <= fact_q || use_part;
            first_q <= first_d;
            last_q <= last_d;
            pb_q <= pb_d;
            flen_q <= pay;
            fenc_q <= enc_q;
            // cipher starts after the header check
            eoff_q <= (fact_q || use_part) ? `UFR_FRAGMENT_HEADER_LEN
               : `UFR_PKT_ENC_OFF;
            hcs_q <= hcs_d;
            // Number travels with its check byte, not the live counter
            fseq_q <= seq_q;
         end
      end
   end

   // plain request, skipped if already piggybacked
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         req_valid_q <= 1'b0;
         req_len_q <= 16'h0000;
      end else begin
         req_valid_q <= (state_q == UFR_REQ);
         if (state_q == UFR_REQ) begin
            req_len_q <= need;
         end
      end
   end

   // User side status
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ready_q <= 1'b0;
         done_q <= 1'b0;
         drop_q <= 1'b0;
         nreq_q <= 1'b0;
         pbdone_q <= 1'b0;
      end else begin
         ready_q <= (state_d == UFR_IDLE) && !(frame_valid && ready_q);
         done_q <= (state_q == UFR_WAIT) && use_full;
         drop_q <= (state_q == UFR_WAIT) && (state_d == UFR_IDLE)
            && !use_full;
         nreq_q <= (state_q == UFR_WAIT) && use_full && (pb_d != 16'h0000);
         if (state_q == UFR_WAIT && use_full) begin
            pbdone_q <= (pb_d != 16'h0000);
         end else if (state_q == UFR_IDLE && frame_valid && ready_q) begin
            pbdone_q <= 1'b0;
         end
      end
   end

   assign lnk.req_valid = req_valid_q;
   assign lnk.req_len = req_len_q;
   assign lnk.frag_valid = frag_valid_q;
   assign lnk.frag_fragd = fragd_q;
   assign lnk.frag_first = first_q;
   assign lnk.frag_last = last_q;
   assign lnk.frag_seq = fseq_q;
   assign lnk.frag_pb = pb_q;
   assign lnk.frag_len = flen_q;
   assign lnk.frag_enc = fenc_q;
   assign lnk.frag_enc_off = eoff_q;
   assign lnk.frag_hcs = hcs_q;
   assign frame_ready = ready_q;
   assign frame_done = done_q;
   assign frame_drop = drop_q;
   assign next_req_sent = nreq_q;
endmodule : ufr_modem

//--- logic/ufr_pkg.sv
// Types shared by the fragmenter ends
package ufr_pkg;
   typedef logic [15:0] ufr_len_t;
   typedef logic [3:0] ufr_seq_t;
   typedef enum logic [2:0] {
      UFR_IDLE, UFR_REQ, UFR_WAIT, UFR_BOFF
   } ufr_state_e;
endpackage : ufr_pkg

//--- testbench/tb.sv
// Testbench joining modem and headend fragmenter ends
`timescale 1ns/1ps
`include "ufr_map.svh"
module tb;
   import ufr_pkg::*;
   logic clk_sys = 1'b0, nrst = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, frame_ok, frame_ready, frame_done, frame_drop;
   logic frame_valid = 1'b0, frame_frag_en = 1'b0, frame_imm = 1'b0;
   logic frame_enc = 1'b0, next_valid = 1'b0, next_req_sent;
   ufr_len_t fr_len = 16'h0000, next_len = 16'h0000, he_len, dec_off;
   ufr_len_t rem, sum, cur_len, ln;
   logic last_pend = 1'b0, cur_enc = 1'b0, hold_on = 1'b0;
   int error_cnt = 0, cmp_count = 0, nreq, nfr, exp_ok = 0, i, m;
   int done_cnt = 0, drop_cnt = 0, ok_cnt = 0, nrs_cnt = 0;
   logic [15:0] rnd = 16'h0052;
   ufr_if ufr_if_i ();
   ufr_modem #(.ACK_CYC(40), .BACKOFF_CYC(4), .MAX_RETRY(3)) ufr_modem_i (
      .clk_sys(clk_sys), .nrst(nrst), .lnk(ufr_if_i.modem),
      .frame_valid(frame_valid), .frame_len(fr_len),
      .frame_frag_en(frame_frag_en), .frame_imm(frame_imm),
      .frame_enc(frame_enc), .next_valid(next_valid), .next_len(next_len),
      .frame_ready(frame_ready), .frame_done(frame_done),
      .frame_drop(frame_drop), .next_req_sent(next_req_sent));
   ufr_headend #(.MAP_CYC(20)) ufr_headend_i (
      .clk_sys(clk_sys), .nrst(nrst), .lnk(ufr_if_i.headend), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_ok(frame_ok), .frame_len(he_len), .dec_off(dec_off));
   ufr_props ufr_props_i (
      .clk_sys(clk_sys), .nrst(nrst), .frag_cap_en(ufr_if_i.frag_cap_en),
      .map_valid(ufr_if_i.map_valid), .map_grant(ufr_if_i.map_grant),
      .map_pend(ufr_if_i.map_pend), .frag_valid(ufr_if_i.frag_valid),
      .frag_fragd(ufr_if_i.frag_fragd), .frag_first(ufr_if_i.frag_first),
      .frag_last(ufr_if_i.frag_last), .frag_seq(ufr_if_i.frag_seq),
      .frag_pb(ufr_if_i.frag_pb), .frag_len(ufr_if_i.frag_len),
      .frag_enc(ufr_if_i.frag_enc), .frag_enc_off(ufr_if_i.frag_enc_off));
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      chk({31'h0, pslverr}, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Offer one frame and wait for its outcome
   task automatic run_frame(input ufr_len_t l, input logic fen, imm, enc,
      input logic exp_done, input logic hold);
      int d0;
      d0 = drop_cnt;
      do @(posedge clk_sys); while (frame_ready !== 1'b1);
      frame_valid <= 1'b1;
      fr_len <= l;
      frame_frag_en <= fen;
      frame_imm <= imm;
      frame_enc <= enc;
      @(posedge clk_sys);
      frame_valid <= 1'b0;
      if (hold) begin
         repeat (30) @(negedge clk_sys);
         hold_on = 1'b1;
         repeat (100) @(negedge clk_sys);
         hold_on = 1'b0;
         chk(nreq, 1);
         apb(1'b1, `UFR_REG_CTRL, 32'h3);
      end
      while (done_cnt + drop_cnt == exp_ok + d0) @(posedge clk_sys);
      chk(drop_cnt - d0, !exp_done);
      if (exp_done) exp_ok++;
      repeat (4) @(posedge clk_sys);
      chk(ok_cnt, exp_ok);
   endtask : run_frame
   always @(posedge clk_sys) begin
      if (nrst) begin
         if (frame_valid && frame_ready === 1'b1) begin
            rem = fr_len;
            cur_len = fr_len;
            cur_enc = frame_enc;
            sum = 0;
            nreq = 0;
            nfr = 0;
         end
         if (ufr_if_i.req_valid === 1'b1) begin
            nreq++;
            chk(ufr_if_i.req_len, rem + 32 + (sum != 0 ? 16 : 0));
         end
         if (ufr_if_i.frag_valid === 1'b1) begin
            ln = ufr_if_i.frag_len;
            if (ufr_if_i.frag_fragd) nfr++;
            if (ufr_if_i.frag_fragd && !ufr_if_i.frag_last) begin
               chk(ufr_if_i.frag_pb, last_pend ? 0 : rem - ln + 48);
               chk(rem - ln > 48, 1);
            end else begin
               chk(ln, rem);
               chk(ufr_if_i.frag_pb,
                  (next_valid && !last_pend) ? next_len + 32 : 0);
            end
            rem = rem - ln;
            sum = sum + ln;
         end
         if (ufr_if_i.map_valid === 1'b1) begin
            last_pend = ufr_if_i.map_pend;
            if (hold_on) chk({ufr_if_i.map_pend, ufr_if_i.map_grant},
               32'h10000);
         end
         if (frame_done === 1'b1) begin
            done_cnt++;
            chk(sum, cur_len);
         end
         if (frame_drop === 1'b1) drop_cnt++;
         if (next_req_sent === 1'b1) nrs_cnt++;
         if (frame_ok === 1'b1) begin
            ok_cnt++;
            chk(he_len, cur_len);
            if (cur_enc && nfr != 0) chk(dec_off, `UFR_FRAGMENT_HEADER_LEN);
         end
      end
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      // Reset values, then an unmapped word and a read-only write
      for (i = 0; i < 5; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         chk(q, (i == 1) ? 32'h100 : 32'h0);
      end
      apb(1'b1, `UFR_REG_FRAMES, 32'h5);
      apb(1'b0, `UFR_REG_FRAMES, 32'h0);
      chk(q, 32'h0);
      for (m = 0; m < 2; m++) begin
         apb(1'b1, `UFR_REG_CTRL, m ? 32'h3 : 32'h1);
         apb(1'b0, `UFR_REG_CTRL, 32'h0);
         chk(q, m ? 32'h3 : 32'h1);
         for (i = 0; i < 5; i++) begin
            rnd = lfsr(rnd);
            ln = (i == 0) ? 16'h00E0 : (i == 1) ? 16'h00E1 :
               16'(300 + rnd % 700);
            run_frame(ln, 1'b1, 1'b0, rnd[3], 1'b1, 1'b0);
         end
      end
      apb(1'b1, `UFR_REG_CTRL, 32'h1);
      next_valid <= 1'b1;
      next_len <= 16'h0064;
      run_frame(16'h00C8, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      next_valid <= 1'b0;
      chk(nrs_cnt, 1);
      run_frame(16'h0064, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      chk(nreq, 0);
      // Capability off, flow off, immediate data: each runs out of retries
      for (i = 0; i < 3; i++) begin
         apb(1'b1, `UFR_REG_CTRL, 32'(i != 0));
         run_frame(16'h0258, i != 1, i == 2, 1'b0, 1'b0, 1'b0);
         chk(nreq, 4);
         chk(nfr, 0);
      end
      apb(1'b1, `UFR_REG_CTRL, 32'h7);
      run_frame(16'h0258, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      apb(1'b0, `UFR_REG_FRAMES, 32'h0);
      chk(q, exp_ok);
      report_and_stop();
   end
endmodule : tb

//--- testbench/ufr_props.sv
// Checker of the fragmenter link signals
`timescale 1ns/1ps
`include "ufr_map.svh"
module ufr_props (
   input wire logic clk_sys, // System clock
   input wire logic nrst, // Async reset, active low
   input wire logic frag_cap_en, // Fragmentation allowed
   input wire logic map_valid, // Map pulse
   input wire ufr_pkg::ufr_len_t map_grant, // Grant bytes
   input wire logic map_pend, // Grant pending
   input wire logic frag_valid, // Unit sent
   input wire logic frag_fragd, // Fragment header present
   input wire logic frag_first, // First flag
   input wire logic frag_last, // Last flag
   input wire ufr_pkg::ufr_seq_t frag_seq, // Sequence number
   input wire ufr_pkg::ufr_len_t frag_pb, // Piggyback bytes
   input wire ufr_pkg::ufr_len_t frag_len, // Payload bytes
   input wire logic frag_enc, // Encrypted
   input wire ufr_pkg::ufr_len_t frag_enc_off // Cipher start
);
   import ufr_pkg::*;
   ufr_seq_t seq_q;
   logic seq_ok_q;
   logic in_frag_q;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         seq_q <= '0;
         seq_ok_q <= 1'b0;
      end else if (frag_valid && frag_fragd) begin
         seq_q <= frag_seq;
         seq_ok_q <= 1'b1;
      end
   end
   // Drops mid-frame would leave this set; bench never makes one
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         in_frag_q <= 1'b0;
      end else if (frag_valid && frag_fragd) begin
         in_frag_q <= !frag_last;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_grant_frag;
      map_valid ##1 frag_valid;
   endsequence
   sequence s_pend_frag;
      map_valid && map_pend ##1 frag_valid;
   endsequence
   a_frag_after_map: assert property (frag_valid |-> $past(map_valid))
      else $error("unit sent without a map");
   a_fill_grant: assert property (s_grant_frag ##0 (frag_fragd && !frag_last)
      |-> frag_len == $past(map_grant) - (`UFR_POH + `UFR_FRAG_OVH))
      else $error("partial grant not filled");
   a_pend_no_pb: assert property (s_pend_frag |-> frag_pb == 16'h0000)
      else $error("piggyback despite grant pending");
   a_first_not_last: assert property (frag_valid && frag_first
      |-> frag_fragd && !frag_last)
      else $error("first fragment flags wrong");
   a_last_not_first: assert property (frag_valid && frag_last
      |-> frag_fragd && !frag_first)
      else $error("last fragment flags wrong");
   a_no_refirst: assert property (frag_valid && frag_fragd && in_frag_q
      |-> !frag_first)
      else $error("middle fragment marked first");
   a_new_is_first: assert property (frag_valid && frag_fragd && !in_frag_q
      |-> frag_first)
      else $error("new fragmentation not marked first");
   a_seq_step: assert property (frag_valid && frag_fragd && seq_ok_q
      |-> frag_seq == seq_q + 4'h1)
      else $error("sequence number did not step");
   a_enc_offset: assert property (frag_valid && frag_enc |-> frag_enc_off ==
      (frag_fragd ? `UFR_FRAGMENT_HEADER_LEN : `UFR_PKT_ENC_OFF))
      else $error("cipher start offset wrong");
   a_frag_cap_on: assert property (frag_valid && frag_fragd
      |-> $past(frag_cap_en))
      else $error("fragment while capability off");
endmodule : ufr_props
